//--- design/spi_target_cfg.svh
`ifndef SPI_TARGET_CFG_SVH
`define SPI_TARGET_CFG_SVH
// frame layout
`define FRAME_BITS 16
`define ADDR_LSB 0
`define ADDR_MSB 6
`define ACCESS_BIT 7
`define DATA_LSB 8
`define DATA_MSB 15
// response bit that carries the error flag (first bit out)
`define ERR_BIT 0
`endif

//--- design/spi_target_pkg.sv
package spi_target_pkg;
    typedef enum logic [1:0] {
        LINK_IDLE,
        LINK_BUSY,
        LINK_DONE
    } link_state_t;
    typedef logic [15:0] word_t;
endpackage

//--- design/word_buffer.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two-entry buffer, valid/ready both sides
// ----------------------------------------
module word_buffer #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_r [2];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] count_r;
    logic push;
    logic pop;

    initial begin
        if (WIDTH < 1) $error("word_buffer width must be positive");
    end

    assign in_ready = (count_r != 2'd2);
    assign out_valid = (count_r != 2'd0);
    assign out_data = mem_r[rd_ptr_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage write, flip-flops indexed by pointer
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'd0;
        end else begin
            if (push) wr_ptr_r <= ~wr_ptr_r;
            if (pop) rd_ptr_r <= ~rd_ptr_r;
            count_r <= count_r + {1'b0, push} - {1'b0, pop};
        end
    end

    AST_BUF_NO_OVERFLOW: assert property (@(posedge clk) disable iff (!rst_n)
        count_r <= 2'd2) else $error("buffer count above two");
endmodule // word_buffer
`default_nettype wire

//--- design/spi_target_frame_interface.sv
`timescale 1ns/1ps
`default_nettype none
`include "spi_target_cfg.svh"
module spi_target_frame_interface
    import spi_target_pkg::*;
#(
    parameter int FRAME_W = `FRAME_BITS
) (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic SPI_CLK,
    input wire logic SPI_CS_N,
    input wire logic SPI_SDI,
    output logic SPI_SDO,
    output logic SPI_SDO_OE,
    input wire logic RESTART_STATE,
    input wire logic [15:0] RESP_WORD,
    output logic CMD_VALID,
    input wire logic CMD_READY,
    output logic [6:0] CMD_ADDR,
    output logic CMD_ACCESS,
    output logic [7:0] CMD_DATA,
    output logic RESP_LATCH
);
    initial begin
        if (FRAME_W != 16) $error("frame width must be 16");
    end

    // ----------------------------------------
    // link domain (SPI_CLK), cs as async reset
    // ----------------------------------------
    // rx shift and clock count run only while selected; cs high clears them
    logic [15:0] rx_sr_r;
    logic [4:0] bit_cnt_r;
    logic cnt_flag_r;

    // sample input on falling clock edge, LSB-first into top
    always_ff @(negedge SPI_CLK or posedge SPI_CS_N) begin
        if (SPI_CS_N) begin
            rx_sr_r <= 16'h0000;
            bit_cnt_r <= 5'd0;
        end else begin
            rx_sr_r <= {SPI_SDI, rx_sr_r[15:1]};
            if (bit_cnt_r != 5'd31) bit_cnt_r <= bit_cnt_r + 5'd1;
        end
    end

    // clock seen flag: set by the first falling edge, cleared by cs high
    always_ff @(negedge SPI_CLK or posedge SPI_CS_N) begin
        if (SPI_CS_N) cnt_flag_r <= 1'b0;
        else cnt_flag_r <= 1'b1;
    end

    // ----------------------------------------
    // system domain
    // ----------------------------------------
    logic [2:0] cs_sync_r;
    logic cs_low;
    logic cs_rise;
    logic [1:0] flag_sync_r;
    logic buf_out_ready;
    logic err_pend_r;
    logic [15:0] resp_r;
    logic buf_in_ready;
    logic buf_out_valid;
    logic [15:0] buf_out_data;
    logic buf_push;

    // two-stage sync of chip select; third stage for edge detect
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cs_sync_r <= 3'b111;
        end else begin
            cs_sync_r <= {cs_sync_r[1:0], SPI_CS_N};
        end
    end
    assign cs_low = ~cs_sync_r[1];
    assign cs_rise = cs_sync_r[1] & ~cs_sync_r[2];

    // clock-seen flag crosses through two flops; it falls with cs high, so
    // its synced copy lags exactly like the chip select sync and stays aligned
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            flag_sync_r <= 2'b00;
        end else begin
            flag_sync_r <= {flag_sync_r[0], cnt_flag_r};
        end
    end

    // hmm: rx cleared asynchronously on cs high; capture via shadow instead
    logic [15:0] rx_shadow_r;
    logic [4:0] cnt_shadow_r;
    always_ff @(negedge SPI_CLK) begin
        rx_shadow_r <= {SPI_SDI, rx_sr_r[15:1]};
        cnt_shadow_r <= (bit_cnt_r == 5'd31) ? bit_cnt_r : bit_cnt_r + 5'd1;
    end

    // frame verdict: push good words, flag bad counts or restart frames
    // limitation: a frame whose clocked part is shorter than one system
    // cycle may pass unseen here, like a zero-clock frame
    logic frame_ok;
    logic seen_hold_r;
    logic restart_seen_r;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            seen_hold_r <= 1'b0;
            restart_seen_r <= 1'b0;
        end else begin
            if (cs_low && flag_sync_r[1]) seen_hold_r <= 1'b1;
            else if (!cs_low && !cs_rise) seen_hold_r <= 1'b0;
            if (cs_low && RESTART_STATE) restart_seen_r <= 1'b1;
            else if (!cs_low && !cs_rise) restart_seen_r <= 1'b0;
        end
    end
    assign frame_ok = (cnt_shadow_r == 5'd16) && seen_hold_r && !restart_seen_r;
    assign buf_push = cs_rise && frame_ok;

    // error flag pends until a clocked good frame ends; every frame shows it in its first bit
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            err_pend_r <= 1'b0;
        end else if (cs_rise && seen_hold_r && !frame_ok) begin
            err_pend_r <= 1'b1;
        end else if (cs_rise && seen_hold_r) begin
            err_pend_r <= 1'b0;
        end
    end

    // response captured while idle; frozen during a frame for the link side
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            resp_r <= 16'h0000;
            RESP_LATCH <= 1'b0;
        end else begin
            RESP_LATCH <= cs_rise;
            if (!cs_low && !cs_rise) begin
                resp_r <= {RESP_WORD[15:1], RESP_WORD[0] | err_pend_r};
            end
        end
    end

    // output pin: bit 0 of response first, then response bits 1 to 15 in order
    logic first_bit_r;
    always_ff @(posedge SPI_CLK or posedge SPI_CS_N) begin
        if (SPI_CS_N) first_bit_r <= 1'b1;
        else first_bit_r <= 1'b0;
    end
    logic [3:0] out_idx_r;
    always_ff @(posedge SPI_CLK or posedge SPI_CS_N) begin
        if (SPI_CS_N) out_idx_r <= 4'd0;
        else if (out_idx_r != 4'd15) out_idx_r <= out_idx_r + 4'd1;
    end
    always_comb begin
        SPI_SDO = resp_r[out_idx_r];
        SPI_SDO_OE = ~SPI_CS_N;
    end

    word_buffer #(
        .WIDTH(16)
    ) u_buf (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .in_valid(buf_push),
        .in_ready(buf_in_ready),
        .in_data(rx_shadow_r),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );

    // pop exactly when the command register loads, so no word is sent twice
    assign buf_out_ready = !CMD_VALID || CMD_READY;

    // decode buffered word into address, access type and data byte
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            CMD_VALID <= 1'b0;
            CMD_ADDR <= 7'h00;
            CMD_ACCESS <= 1'b0;
            CMD_DATA <= 8'h00;
        end else if (!CMD_VALID || CMD_READY) begin
            CMD_VALID <= buf_out_valid;
            CMD_ADDR <= buf_out_data[`ADDR_MSB:`ADDR_LSB];
            CMD_ACCESS <= buf_out_data[`ACCESS_BIT];
            CMD_DATA <= buf_out_data[`DATA_MSB:`DATA_LSB];
        end
    end

    AST_OE_FOLLOWS_CS: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        SPI_CS_N |-> !SPI_SDO_OE) else $error("output driven while deselected");
    AST_PUSH_ON_RISE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        buf_push |-> cs_rise && !restart_seen_r) else $error("bad push");
    AST_NO_DROP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        buf_push |-> buf_in_ready) else $error("word pushed into full buffer");
    AST_ERR_SET: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        cs_rise && seen_hold_r && cnt_shadow_r != 5'd16 |=> err_pend_r)
        else $error("error flag not set");
    AST_CMD_VALID: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        buf_push |-> ##[1:8] CMD_VALID) else $error("command not delivered");
    AST_CMD_HOLD: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        CMD_VALID && !CMD_READY |=> CMD_VALID && $stable(CMD_ADDR))
        else $error("command dropped under stall");
    AST_ERR_IN_RESP: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        err_pend_r && !cs_low && !cs_rise |=> resp_r[0]) else $error("error not shown");
    AST_ACCESS_BIT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        (!CMD_VALID || CMD_READY) && buf_out_valid |=> CMD_ACCESS == $past(buf_out_data[7]))
        else $error("access bit wrong");
    AST_RESP_FROZEN: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
        cs_low |=> $stable(resp_r)) else $error("response changed in frame");
    COV_GOOD: cover property (@(posedge SYS_CLK) buf_push);
    COV_ERR: cover property (@(posedge SYS_CLK) $rose(err_pend_r));
    COV_STALL: cover property (@(posedge SYS_CLK) CMD_VALID && !CMD_READY);
    COV_RESTART: cover property (@(posedge SYS_CLK) cs_rise && restart_seen_r);
endmodule // spi_target_frame_interface
`default_nettype wire

//--- bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host that masters the serial port
// ----------------------------------------
module host_model (
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    // idle: deselected, clock parked low so the error bit is valid at select
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end

    // one frame of n clocks, 6 ns link period, clock runs only inside it
    task automatic frame(input int n, input logic [15:0] tx, output logic [15:0] rx,
                         output logic oe, output logic first);
        rx = 16'h0000;
        #2;
        cs_n = 1'b0;
        #3;
        first = sdo;
        oe = sdo_oe;
        for (int i = 0; i < n; i++) begin
            sdi = tx[i % 16];
            #1.5;
            rx[i % 16] = sdo;
            sclk = 1'b1;
            #3;
            sclk = 1'b0;
            #1.5;
        end
        // hold select long enough for the system side to see every frame
        #21;
        cs_n = 1'b1;
        #1;
        sdi = ~sdi; // stale data must not look meaningful
    endtask
endmodule // host_model
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// self-checking bench
// ----------------------------------------
module testbench;
    import spi_target_pkg::*;
    logic sys_clk = 1'b0, rst_n = 1'b0, restart = 1'b0, cmd_ready = 1'b0;
    logic spi_clk, cs_n, sdi, sdo, sdo_oe, cmd_valid, cmd_access, resp_latch, oe, first;
    logic [6:0] cmd_addr;
    logic [7:0] cmd_data;
    word_t resp = 16'h0000, rx;
    wire sdo_line;
    int failures = 0, cmp_count = 0, latch_cnt = 0;

    spi_target_frame_interface #(.FRAME_W(16)) dut (.SYS_CLK(sys_clk), .RST_N(rst_n),
        .SPI_CLK(spi_clk), .SPI_CS_N(cs_n), .SPI_SDI(sdi), .SPI_SDO(sdo),
        .SPI_SDO_OE(sdo_oe), .RESTART_STATE(restart), .RESP_WORD(resp),
        .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_ADDR(cmd_addr),
        .CMD_ACCESS(cmd_access), .CMD_DATA(cmd_data), .RESP_LATCH(resp_latch));
    host_model host (.sclk(spi_clk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_line), .sdo_oe(sdo_oe));
    assign sdo_line = sdo_oe ? sdo : 1'bz; // no pull on the shared line

    initial forever #5 sys_clk = ~sys_clk;

    // count response latch pulses away from the edge that launches them
    always @(negedge sys_clk) if (resp_latch === 1'b1) latch_cnt <= latch_cnt + 1;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // response loaded while deselected, then frame, then the required gap
    task automatic xfer(input int n, input word_t tx, input word_t r, input logic rs);
        int latch_before;
        @(posedge sys_clk) resp <= r;
        restart <= rs;
        repeat (2) @(posedge sys_clk);
        latch_before = latch_cnt;
        host.frame(n, tx, rx, oe, first);
        @(posedge sys_clk) restart <= 1'b0;
        repeat (8) @(posedge sys_clk);
        check({15'h0000, oe}, 16'h0001);
        check(16'(latch_cnt - latch_before), 16'h0001);
        @(negedge sys_clk) check({15'h0000, sdo_oe}, 16'h0000);
    endtask

    // bounded wait for one command, then accept it with a one-cycle ready
    task automatic get_cmd(input word_t tx);
        int k;
        for (k = 0; k < 20 && cmd_valid !== 1'b1; k++) @(negedge sys_clk);
        check({15'h0000, cmd_valid}, 16'h0001);
        check({cmd_data, cmd_access, cmd_addr}, tx);
        @(posedge sys_clk) cmd_ready <= 1'b1;
        @(posedge sys_clk) cmd_ready <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic no_cmd();
        logic seen = 1'b0;
        repeat (20) @(negedge sys_clk) seen |= (cmd_valid !== 1'b0);
        check({15'h0000, seen}, 16'h0000);
    endtask

    task automatic t_basic();
        xfer(16, 16'h5A81, 16'hA5C2, 1'b0);
        check(rx, 16'hA5C2);
        check({15'h0000, first}, 16'h0000);
        get_cmd(16'h5A81);
        check({15'h0000, cmd_valid}, 16'h0000);
        $display("test basic done");
    endtask

    // receiver stalls across two frames; neither word may be lost
    task automatic t_stall();
        xfer(16, 16'h3C7F, 16'h1234, 1'b0);
        xfer(16, 16'hC300, 16'h4321, 1'b0);
        check(rx, 16'h4321);
        get_cmd(16'h3C7F);
        get_cmd(16'hC300);
        check({15'h0000, cmd_valid}, 16'h0000);
        $display("test stall done");
    endtask

    task automatic t_count();
        xfer(5, 16'hFFFF, 16'h0000, 1'b0);
        no_cmd();
        xfer(0, 16'h0000, 16'h0000, 1'b0);
        check({15'h0000, first}, 16'h0001);
        no_cmd();
        xfer(16, 16'h1122, 16'h0F0E, 1'b0);
        // a zero-clock frame only reads the flag; it stays until a counted frame
        check(rx, 16'h0F0F);
        get_cmd(16'h1122);
        $display("test count done");
    endtask

    task automatic t_restart();
        xfer(16, 16'h7705, 16'h0000, 1'b1);
        no_cmd();
        xfer(16, 16'h0906, 16'h0000, 1'b0);
        check(rx, 16'h0001);
        get_cmd(16'h0906);
        $display("test restart done");
    endtask

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_basic();
        t_stall();
        t_count();
        t_restart();
        end_of_test();
    end

    // watchdog: the tests need well under 10 us
    initial begin
        #100000;
        failures++;
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
